//--- hw/tic_icache.sv
`timescale 1ns/10ps
// Functional notes
// [RL1] 16 KB two-way set-associative array
// [RL2] 512 lines, two ways, 256 sets
// [RL3] 32-byte aligned lines with a tag
// [RL4] one LEAST_RECENT_MARKER bit; fill replaces LEAST_RECENT_MARKER way
// [RL5] instruction lines carry no modified bit
// [RL6] data cache indexes and tags physically
// [RL7] index from effective, tag from physical
// [RL8] compare both tags: hit or miss
// [RL9] data hit copies line into buffer
// [RL10] ignore two low address bits, read word
// [RL11] hit goes to buffer, two per cycle
// [RL12] miss or non-cacheable goes to bus
// [RL13] non-cacheable size: four or eight words
// [RL14] issued fetches always run to completion
// [RL15] target word first; any return order
// [RL16] forward target from fill buffer immediately
// [RL17] later fetches served from fill buffer
// [RL18] write line only after all words
// [RL19] fill buffer keeps eight non-cacheable words
// [RL20] one invalidate clears every line
// [RL21] hits served while fill in progress
// [RL22] own 64-bit instruction bus interface
// [RL23] region map resets to all non-cacheable
// [RL24] valid bit: invalidate clears, fill sets
module tic_icache
    import tic_pkg::*;
#(
    parameter int P_CACHE_BYTES = CACHE_BYTES,
    parameter int P_LINE_BYTES  = LINE_BYTES,
    parameter int P_BUS_BITS    = BUS_BITS
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_fetch_valid,
    input  wire logic [31:0] i_fetch_ea,
    input  wire logic [31:0] i_fetch_pa,
    input  wire logic        i_xlate_en,
    input  wire logic        i_page_cacheable,
    output logic             o_fetch_ready,
    output logic             o_instr_valid,
    output logic [63:0]      o_instr_data,
    output logic             o_instr_two,
    input  wire logic        i_invalidate,
    input  wire logic        i_ncache_full_line,
    input  wire logic        i_region_map_we,
    input  wire logic [31:0] i_region_map_wdata,
    output logic [31:0]      o_region_map,
    output logic             o_fill_busy,
    output logic             o_bus_req,
    output logic [31:0]      o_bus_addr,
    output logic             o_bus_full_line,
    input  wire logic        i_bus_ack,
    input  wire logic        i_bus_rd_valid,
    input  wire logic [1:0]  i_bus_rd_beat,
    input  wire logic [63:0] i_bus_rd_data
);

    // see [RL1] see [RL2] see [RL3] see [RL22]
    if (P_CACHE_BYTES != NUM_LINES * P_LINE_BYTES ||
        P_LINE_BYTES != LINE_BYTES || P_BUS_BITS != BUS_BITS) begin : g_chk
        $error("tic_icache: geometry parameters not supported");
    end

    // arrays: no modified bit, lines are never written newer, see [RL5]
    logic [LINE_BITS-1:0] data_mem [NUM_WAYS][NUM_SETS];
    logic [TAG_W-1:0]     tag_mem  [NUM_WAYS][NUM_SETS];
    logic [NUM_SETS-1:0]  valid_way [NUM_WAYS];
    logic [NUM_SETS-1:0]  least_recent_marker;

    tic_fill_t            state;
    logic [LINE_BITS-1:0] fb_data;
    logic [7:0]           fb_words;
    logic [7:0]           fb_expect;
    logic [LADDR_W-1:0]   fb_line;
    logic                 fb_cache;
    logic [IDX_W-1:0]     fb_set;
    logic [TAG_W-1:0]     fb_tag;
    logic                 fb_way;
    logic                 pend;
    logic [2:0]           pend_wsel;
    logic [LINE_BITS-1:0] line_buf;

    logic [IDX_W-1:0]     idx;
    logic [TAG_W-1:0]     tag;
    logic [2:0]           wsel;
    logic [2:0]           wnext;
    logic                 cacheable;
    logic                 hit0;
    logic                 hit1;
    logic                 cache_hit;
    logic                 fb_match;
    logic                 accept;
    logic                 serve_cache;
    logic                 serve_fb;
    logic                 start_miss;
    logic [LINE_BITS-1:0] hit_line;
    logic [7:0]           beat_mask;
    logic [7:0]           next_words;
    logic                 fill_done;
    logic                 fwd;

    // index from effective bits, tag from translated bits, see [RL7]
    // the data side would use the physical address for both, see [RL6]
    assign idx   = tic_index(i_fetch_ea);
    assign tag   = tic_tag(i_fetch_pa);
    // byte lanes dropped, always a whole word, see [RL10]
    assign wsel  = i_fetch_ea[4:2];
    assign wnext = wsel + 3'h1;

    assign cacheable = i_xlate_en ? i_page_cacheable
                                  : o_region_map[i_fetch_pa[31:REGION_LSB]];

    // both ways compared in the chosen set, see [RL8]
    assign hit0      = valid_way[0][idx] && (tag_mem[0][idx] == tag);
    assign hit1      = valid_way[1][idx] && (tag_mem[1][idx] == tag);
    assign cache_hit = cacheable && (hit0 || hit1);
    assign hit_line  = hit1 ? data_mem[1][idx] : data_mem[0][idx];

    // fill buffer reuse, also for non-cacheable words, see [RL17] see [RL19]
    assign fb_match = (fb_line == tic_line(i_fetch_pa)) && fb_words[wsel];

    // hits wait only until the target word is forwarded; a new miss waits for the fill, see [RL21]
    assign o_fetch_ready = !pend &&
                           (state == TIC_IDLE || cache_hit || fb_match);
    assign accept      = i_fetch_valid && o_fetch_ready;
    assign serve_cache = accept && cache_hit;
    assign serve_fb    = accept && !cache_hit && fb_match;
    assign start_miss  = accept && !cache_hit && !fb_match;  // see [RL12]

    always_comb begin
        beat_mask = 8'h00;
        if (i_bus_rd_valid && state != TIC_IDLE && state != TIC_DONE) begin
            beat_mask[{i_bus_rd_beat, 1'b0} +: 2] = 2'b11;
        end
    end

    // any arrival order is fine: completion is a coverage mask, see [RL15]
    assign next_words = fb_words | beat_mask;
    assign fill_done  = (state == TIC_DATA || state == TIC_REQ) &&
                        ((next_words & fb_expect) == fb_expect);
    assign fwd = pend && (beat_mask != 8'h00) &&
                 (i_bus_rd_beat == pend_wsel[2:1]);
    assign o_fill_busy = (state != TIC_IDLE);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_region_map <= REGION_MAP_RST;  // see [RL23]
        end else if (i_region_map_we) begin
            o_region_map <= i_region_map_wdata;
        end
    end

    // no input can cancel a fill once started, see [RL14]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= TIC_IDLE;
        end else begin
            case (state)
                TIC_IDLE: begin
                    if (start_miss) begin
                        state <= TIC_REQ;
                    end
                end
                TIC_REQ: begin
                    if (i_bus_ack) begin
                        state <= fill_done ? TIC_DONE : TIC_DATA;
                    end
                end
                TIC_DATA: begin
                    if (fill_done) begin
                        state <= TIC_DONE;
                    end
                end
                TIC_DONE: begin
                    state <= TIC_IDLE;
                end
                default: begin
                    state <= TIC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_bus_req       <= 1'b0;
            o_bus_addr      <= 32'h0000_0000;
            o_bus_full_line <= 1'b0;
        end else if (start_miss) begin
            o_bus_req       <= 1'b1;
            // target word address goes out first, see [RL15]
            o_bus_addr      <= {i_fetch_pa[31:2], 2'b00};
            // cacheable misses fetch a line, see [RL12] see [RL13]
            o_bus_full_line <= cacheable || i_ncache_full_line;
        end else if (i_bus_ack) begin
            o_bus_req <= 1'b0;
        end
    end

    // fill buffer collects beats, see [RL16] see [RL19]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fb_words  <= 8'h00;
            fb_expect <= MASK_FULL;
            fb_line   <= '0;
            fb_cache  <= 1'b0;
            fb_set    <= '0;
            fb_tag    <= '0;
            fb_way    <= 1'b0;
            fb_data   <= '0;
        end else if (start_miss) begin
            fb_words  <= 8'h00;
            fb_line   <= tic_line(i_fetch_pa);
            fb_cache  <= cacheable;
            fb_set    <= idx;
            fb_tag    <= tag;
            fb_way    <= least_recent_marker[idx];  // victim is the LEAST_RECENT_MARKER way, see [RL4]
            if (cacheable || i_ncache_full_line) begin
                fb_expect <= MASK_FULL;
            end else begin
                fb_expect <= wsel[2] ? MASK_HIGH_HALF : MASK_LOW_HALF;
            end
        end else begin
            if (i_invalidate && state == TIC_IDLE) begin
                fb_words <= 8'h00;
            end else begin
                fb_words <= next_words;
            end
            if (beat_mask != 8'h00) begin
                fb_data[i_bus_rd_beat*BUS_BITS +: BUS_BITS] <= i_bus_rd_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend      <= 1'b0;
            pend_wsel <= 3'h0;
        end else if (start_miss) begin
            pend      <= 1'b1;
            pend_wsel <= wsel;
        end else if (fwd) begin
            pend <= 1'b0;
        end
    end

    // line written only once complete, see [RL18]
    always_ff @(posedge i_clk) begin
        if (state == TIC_DONE && fb_cache) begin
            data_mem[fb_way][fb_set] <= fb_data;
            tag_mem[fb_way][fb_set]  <= fb_tag;  // see [RL24]
        end
    end

    // invalidate takes priority over a fill landing the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            valid_way[0] <= '0;
            valid_way[1] <= '0;
        end else if (i_invalidate) begin
            valid_way[0] <= '0;  // see [RL20] see [RL24]
            valid_way[1] <= '0;
        end else if (state == TIC_DONE && fb_cache) begin
            valid_way[fb_way][fb_set] <= 1'b1;  // see [RL24]
        end
    end

    // lru holds the way number to replace next, see [RL4]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            least_recent_marker <= '0;
        end else begin
            if (serve_cache) begin
                least_recent_marker[idx] <= !hit1;
            end
            if (state == TIC_DONE && fb_cache) begin
                least_recent_marker[fb_set] <= !fb_way;
            end
        end
    end

    // hit line lands in the line buffer, two words leave per cycle unless the target is the last word of the line
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            line_buf <= '0;
        end else if (serve_cache) begin
            line_buf <= hit_line;  // see [RL9] see [RL11]
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_instr_valid <= 1'b0;
            o_instr_data  <= 64'h0000_0000_0000_0000;
            o_instr_two   <= 1'b0;
        end else begin
            o_instr_valid <= serve_cache || serve_fb || fwd;
            if (serve_cache) begin
                o_instr_data <= {hit_line[wnext*WORD_BITS +: WORD_BITS],
                                 hit_line[wsel*WORD_BITS +: WORD_BITS]};
                o_instr_two  <= (wsel != LAST_WORD);  // see [RL11]
            end else if (serve_fb) begin
                o_instr_data <= {fb_data[wnext*WORD_BITS +: WORD_BITS],
                                 fb_data[wsel*WORD_BITS +: WORD_BITS]};
                o_instr_two  <= (wsel != LAST_WORD) && fb_words[wnext];
            end else if (fwd) begin
                // bypass of the target straight off the bus, see [RL16]
                if (pend_wsel[0]) begin
                    o_instr_data <= {32'h0000_0000, i_bus_rd_data[63:32]};
                    o_instr_two  <= 1'b0;
                end else begin
                    o_instr_data <= i_bus_rd_data;
                    o_instr_two  <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_miss_start;
        start_miss;
    endsequence

    sequence s_req_taken;
        o_bus_req && i_bus_ack;
    endsequence

    a_miss_issues_req: assert property (  // see [RL12]
        s_miss_start |=> o_bus_req && state == TIC_REQ)
        else $error("miss did not raise a bus request");
    a_line_size: assert property (  // see [RL13]
        s_miss_start |=> o_bus_full_line ==
            ($past(cacheable) || $past(i_ncache_full_line)))
        else $error("wrong bus request size");
    a_target_first: assert property (  // see [RL15]
        s_miss_start |=> o_bus_addr[31:2] == $past(i_fetch_pa[31:2]))
        else $error("request does not name the target word");
    a_no_abort: assert property (  // see [RL14]
        s_req_taken |=> state == TIC_DATA || state == TIC_DONE)
        else $error("fill left before completion");
    a_fill_complete: assert property (  // see [RL18]
        state == TIC_DONE |-> (fb_words & fb_expect) == fb_expect)
        else $error("line written before all words arrived");
    a_hit_output: assert property (  // see [RL8]
        serve_cache |=> o_instr_valid && o_instr_data[31:0] ==
            line_buf[$past(wsel)*WORD_BITS +: WORD_BITS])
        else $error("hit did not deliver the addressed word");
    a_bypass_target: assert property (  // see [RL16]
        fwd |=> o_instr_valid && !pend)
        else $error("target word not forwarded on arrival");
    a_flash_inval: assert property (  // see [RL20]
        i_invalidate |=> valid_way[0] == '0 && valid_way[1] == '0)
        else $error("invalidate left a line valid");
    a_hit_in_fill: assert property (  // see [RL21]
        state != TIC_IDLE && i_fetch_valid && !pend && cache_hit |=>
            o_instr_valid)
        else $error("hit blocked by a fill");
    a_fill_sets_valid: assert property (  // see [RL24]
        state == TIC_DONE && fb_cache && !i_invalidate |=>
            valid_way[$past(fb_way)][$past(fb_set)] && least_recent_marker[$past(fb_set)]
            != $past(fb_way))
        else $error("fill did not validate line or update lru");
    a_region_hold: assert property (  // see [RL23]
        !i_region_map_we |=> $stable(o_region_map))
        else $error("region map changed without a write");

endmodule : tic_icache

//--- hw/tic_pkg.sv
package tic_pkg;

    localparam int CACHE_BYTES = 16384;
    localparam int NUM_WAYS    = 2;
    localparam int NUM_SETS    = 256;
    localparam int NUM_LINES   = 512;
    localparam int LINE_BYTES  = 32;
    localparam int LINE_WORDS  = 8;
    localparam int WORD_BITS   = 32;
    localparam int BUS_BITS    = 64;
    localparam int LINE_BITS   = 256;

    localparam int IDX_LSB     = 5;
    localparam int IDX_W       = 8;
    localparam int TAG_LSB     = 13;
    localparam int TAG_W       = 19;
    localparam int LADDR_W     = 27;
    localparam int REGION_LSB  = 27;
    localparam int REGION_W    = 5;

    localparam logic [31:0] REGION_MAP_RST = 32'h0000_0000;
    localparam logic [7:0]  MASK_FULL      = 8'hFF;
    localparam logic [7:0]  MASK_LOW_HALF  = 8'h0F;
    localparam logic [7:0]  MASK_HIGH_HALF = 8'hF0;
    localparam logic [2:0]  LAST_WORD      = 3'h7;

    typedef enum logic [1:0] {
        TIC_IDLE,
        TIC_REQ,
        TIC_DATA,
        TIC_DONE
    } tic_fill_t;

    function automatic logic [IDX_W-1:0] tic_index(input logic [31:0] ea);
        return ea[TAG_LSB-1:IDX_LSB];
    endfunction : tic_index

    function automatic logic [TAG_W-1:0] tic_tag(input logic [31:0] pa);
        return pa[31:TAG_LSB];
    endfunction : tic_tag

    function automatic logic [LADDR_W-1:0] tic_line(input logic [31:0] pa);
        return pa[31:IDX_LSB];
    endfunction : tic_line

endpackage : tic_pkg

//--- testbench/tic_bus_model.sv
`timescale 1ns/10ps
// memory behind the fetch bus; each word is a function of its address
module tic_bus_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_full,
    input  wire logic        i_slow,
    input  wire logic        i_rev,
    output logic             o_ack,
    output logic             o_rd_valid,
    output logic [1:0]       o_rd_beat,
    output logic [63:0]      o_rd_data
);
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'h5A5A_A5A5;
    endfunction : word_at

    logic [31:0] addr;
    logic [1:0]  b;
    logic        slow;
    logic        rev;
    int          nb;
    int          base;

    initial begin
        o_ack = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_beat = 2'h0;
        o_rd_data = 64'h0;
        forever begin
            @(posedge i_clk);
            if (i_rstn && i_req) begin
                addr = i_addr;
                slow = i_slow;
                rev = i_rev;
                nb = i_full ? 4 : 2;
                base = i_full ? 0 : (i_addr[4] ? 2 : 0);
                if (slow) repeat (3) @(posedge i_clk);
                o_ack <= 1'b1;
                @(posedge i_clk);
                o_ack <= 1'b0;
                for (int k = 0; k < nb; k++) begin
                    // any beat order is legal, so both are exercised
                    b = 2'(rev ? base + nb - 1 - k : base + k);
                    o_rd_valid <= 1'b1;
                    o_rd_beat <= b;
                    o_rd_data <= {word_at({addr[31:5], b, 3'h4}),
                                  word_at({addr[31:5], b, 3'h0})};
                    @(posedge i_clk);
                    if (slow) begin
                        o_rd_valid <= 1'b0;
                        o_rd_data <= ~o_rd_data;
                        @(posedge i_clk);
                    end
                end
                // released data must not look like a valid last beat
                o_rd_valid <= 1'b0;
                o_rd_data <= ~o_rd_data;
            end
        end
    end
endmodule : tic_bus_model

//--- testbench/two_way_instruction_cache_test.sv
`timescale 1ns/10ps
module two_way_instruction_cache_test;
    logic        clk = 0, rstn = 0, fv = 0, xl = 0, pc = 0;
    logic        inv = 0, ncf = 0, we = 0, slow = 0, rev = 0;
    logic [31:0] ea = 0, pa = 0, wd = 0;
    logic [31:0] rmap, baddr, last_addr;
    logic        rdy, iv, two, busy, req, bfull, ack, rv, last_full;
    logic [63:0] idata, rd;
    logic [1:0]  beat;
    int          error_cnt = 0, n_compared = 0, n_req = 0;

    always #50 clk = ~clk;

    tic_icache i_tic_icache (.i_clk(clk), .i_rstn(rstn),
        .i_fetch_valid(fv), .i_fetch_ea(ea), .i_fetch_pa(pa),
        .i_xlate_en(xl), .i_page_cacheable(pc), .o_fetch_ready(rdy),
        .o_instr_valid(iv), .o_instr_data(idata), .o_instr_two(two),
        .i_invalidate(inv), .i_ncache_full_line(ncf),
        .i_region_map_we(we), .i_region_map_wdata(wd),
        .o_region_map(rmap), .o_fill_busy(busy), .o_bus_req(req),
        .o_bus_addr(baddr), .o_bus_full_line(bfull), .i_bus_ack(ack),
        .i_bus_rd_valid(rv), .i_bus_rd_beat(beat), .i_bus_rd_data(rd));

    tic_bus_model i_tic_bus_model (.i_clk(clk), .i_rstn(rstn),
        .i_req(req), .i_addr(baddr), .i_full(bfull), .i_slow(slow),
        .i_rev(rev), .o_ack(ack), .o_rd_valid(rv), .o_rd_beat(beat),
        .o_rd_data(rd));

    always @(posedge clk) begin
        if (req === 1'b1 && ack === 1'b1) begin
            n_req++;
            last_addr = baddr;
            last_full = bfull;
        end
    end

    function automatic logic [31:0] mem(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'h5A5A_A5A5;
    endfunction : mem

    task automatic chk(input bit ok, input string m);
        n_compared++;
        if (!ok) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic done(input string t);
        $display("test %s finished", t);
    endtask : done

    task automatic idle;
        int n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(n < 300, "fill did not finish");
    endtask : idle

    // mode 0: bus fill, 1: fill-buffer hit, 2: cache hit
    task automatic fetch(input logic [31:0] a, p, input int mode);
        int n;
        int r0;
        r0 = n_req;
        n = 0;
        @(negedge clk);
        fv = 1;
        ea = a;
        pa = p;
        #1;
        while (rdy !== 1'b1 && n < 300) begin
            @(negedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        fv = 0;
        n = 1;
        while (iv !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(n < 300, "no instruction delivered");
        chk(idata[31:0] === mem(p), "first word");
        if (mode == 0)
            chk(n_req == r0 + 1, "one bus request");
        else
            chk(n_req == r0 && n == 1, "hit latency");
        if (mode == 0)
            chk(two === !p[2] && idata[63:32] ===
                (p[2] ? 32'h0 : mem(p + 4)), "bypass pair");
        if (mode == 2 && p[4:2] != 3'h7)
            chk(two === 1'b1 && idata[63:32] === mem(p + 4),
                "pair");
        if (mode == 2 && p[4:2] == 3'h7)
            chk(two === 1'b0, "pair past line end");
    endtask : fetch

    initial begin
        logic [31:0] a, b, c, d;
        int f;
        void'($urandom(54));
        repeat (6) @(negedge clk);
        rstn = 1;
        chk(rmap === 32'h0 && req === 1'b0 && iv === 1'b0,
            "reset");
        done("reset");
        for (f = 0; f < 2; f++) begin
            ncf = f[0];
            rev = f[0];
            slow = 1'($urandom);
            a = ($urandom & 32'h07FF_FFE0) | 32'h4;
            fetch(a, a, 0);
            chk(last_full === ncf && last_addr === a, "size");
            fetch(a + 4, a + 4, 1);
            if (f == 1) fetch(a + 24, a + 24, 1);
        end
        done("non-cacheable");
        idle();
        @(negedge clk);
        we = 1;
        wd = 32'hFFFF_FFFF;
        inv = 1;
        @(negedge clk);
        we = 0;
        inv = 0;
        chk(rmap === 32'hFFFF_FFFF, "region map");
        a = $urandom & 32'hFFFF_FFE0;
        fetch(a + 12, a + 12, 0);
        chk(last_full === 1'b1, "cacheable full line");
        idle();
        fetch(a + 28, a + 28, 2);
        fetch(a + 11, a + 8, 2);
        fetch(a ^ 32'hABC0_0000, a, 2);
        done("hit");
        slow = 1;
        rev = 0;
        c = a ^ 32'h20;
        fetch(c, c, 0);
        fetch(a + 4, a + 4, 2);
        chk(busy === 1'b1, "fill keeps running");
        idle();
        fetch(c + 28, c + 28, 2);
        done("hit under fill");
        slow = 1'($urandom);
        rev = 1'($urandom);
        b = a ^ 32'h8000_0000 ^ ($urandom & 32'h3FFF_E000);
        d = b ^ 32'h4000_0000;
        fetch(b, b, 0);
        idle();
        fetch(a, a, 2);
        fetch(d, d, 0);
        idle();
        fetch(a, a, 2);
        fetch(b, b, 0);
        idle();
        done("replacement");
        @(negedge clk);
        inv = 1;
        @(negedge clk);
        inv = 0;
        fetch(a, a, 0);
        idle();
        done("invalidate");
        xl = 1;
        ncf = 0;
        fetch(d + 32, d + 32, 0);
        chk(last_full === 1'b0, "page not cacheable");
        idle();
        pc = 1;
        fetch(d + 64, d + 64, 0);
        chk(last_full === 1'b1, "page cacheable");
        done("translated");
        results();
    end

    initial begin
        #2_000_000;
        error_cnt++;
        results();
    end
endmodule : two_way_instruction_cache_test
